// file: logic/rtscd_decoder.sv
/*
 * Real-time control decoder: samples the per-line serial control frame,
 * latches its fields and selects subcarrier source, phase reset and field rate.
 * Assumes the serial input arrives from a pin aligned to clock_in, a start bit
 * (high) opening each frame, and an AXI4-Lite master driving the registers.
 */
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

// Functional notes
// - The received line PLL increment is discarded and steers nothing.
// - With real-time control on and colour decode off or colour bit 1, the subcarrier follows the received increment.
// - With enable, sequence bit 1 inverts the line under PAL; under NTSC it changes nothing.
// - With enable, phase decode on and select 00, a received reset bit resets phase.
// - With enable and field-rate decode on, the received field rate replaces the register.
// - With enable and colour decode on, colour bit 0 uses the internal increment, 1 the received.
// - With enable and colour decode off, the received increment is used whatever the colour bit.
// - Field parity is taken from the received odd/even bit.
module rtscd_decoder (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic rtc_serial_in,
    input wire logic [rtscd_pkg::AXI_AW-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [rtscd_pkg::AXI_AW-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output rtscd_pkg::rtscd_out_s decoded_out
);
    localparam int unsigned FW = rtscd_pkg::FRAME_LEN;

    typedef struct packed {
        logic sync1;
        logic sync2;
        rtscd_pkg::rtscd_rx_e rx;
        logic [5:0] bit_cnt;
        logic [FW-1:0] shift;
        logic [rtscd_pkg::INC_W-1:0] rx_inc;
        logic rx_seq;
        logic rx_reset;
        logic rx_fr;
        logic rx_odd;
        logic rx_color;
        logic frame_done;
        logic [6:0] ctrl;
        logic [rtscd_pkg::INC_W-1:0] reg_inc;
        logic reg_fr;
        logic [31:0] frame_cnt;
        logic aw_held;
        logic [rtscd_pkg::AXI_AW-1:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        rtscd_pkg::rtscd_out_s out;
    } rtscd_state_s;

    rtscd_state_s state_r;
    rtscd_state_s state_nxt;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] din,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = din[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    function automatic logic known_ofs(input logic [rtscd_pkg::AXI_AW-1:0] a);
        return (a == rtscd_pkg::OFS_CTRL) || (a == rtscd_pkg::OFS_SC_INC) ||
               (a == rtscd_pkg::OFS_FIELD) || (a == rtscd_pkg::OFS_STATUS) ||
               (a == rtscd_pkg::OFS_RX_INC);
    endfunction : known_ofs

    logic rt_enable;
    logic do_write;
    logic [31:0] wmerged;

    always_comb begin
        state_nxt = state_r;
        rt_enable = state_r.ctrl[rtscd_pkg::CTL_ENABLE];
        state_nxt.sync1 = rtc_serial_in;
        state_nxt.sync2 = state_r.sync1;
        state_nxt.frame_done = 1'b0;
        // serial receiver
        case (state_r.rx)
            rtscd_pkg::RX_IDLE: begin
                if (state_r.sync2) begin
                    state_nxt.rx = rtscd_pkg::RX_SHIFT;
                    state_nxt.bit_cnt = 6'h00;
                end
            end
            rtscd_pkg::RX_SHIFT: begin
                state_nxt.shift = {state_r.sync2, state_r.shift[FW-1:1]};
                state_nxt.bit_cnt = state_r.bit_cnt + 6'h01;
                if (state_r.bit_cnt == 6'(FW - 1)) begin
                    state_nxt.rx = rtscd_pkg::RX_IDLE;
                    state_nxt.frame_done = 1'b1;
                end
            end
            default: state_nxt.rx = rtscd_pkg::RX_IDLE;
        endcase
        // latch fields once the frame is complete; line increment bits dropped
        if (state_r.frame_done) begin
            state_nxt.rx_inc = state_r.shift[rtscd_pkg::POS_SC_INC +: rtscd_pkg::INC_W];
            state_nxt.rx_seq = state_r.shift[rtscd_pkg::POS_SEQ];
            state_nxt.rx_reset = state_r.shift[rtscd_pkg::POS_RESET];
            state_nxt.rx_fr = state_r.shift[rtscd_pkg::POS_FIELD_RATE];
            state_nxt.rx_odd = state_r.shift[rtscd_pkg::POS_ODD_EVEN];
            state_nxt.rx_color = state_r.shift[rtscd_pkg::POS_COLOR];
            state_nxt.frame_cnt = state_r.frame_cnt + 32'h0000_0001;
        end
        // decoded outputs
        state_nxt.out.use_received_inc = rt_enable &&
            (!state_r.ctrl[rtscd_pkg::CTL_DEC_COL] || state_r.rx_color);
        state_nxt.out.sc_increment = state_nxt.out.use_received_inc ?
            state_r.rx_inc : state_r.reg_inc;
        // one-cycle pulse per frame whose reset bit is set, with enable, phase decode on and select 00
        state_nxt.out.phase_reset = state_r.frame_done && rt_enable &&
            state_r.ctrl[rtscd_pkg::CTL_DEC_PH] &&
            (state_r.ctrl[rtscd_pkg::CTL_PH_SEL +: 2] == 2'h0) &&
            state_r.shift[rtscd_pkg::POS_RESET];
        state_nxt.out.invert_line = rt_enable && state_r.ctrl[rtscd_pkg::CTL_PAL] &&
            state_r.rx_seq;
        // 0 selects 50 Hz, 1 selects 60 Hz
        state_nxt.out.field_rate_60hz = (rt_enable && state_r.ctrl[rtscd_pkg::CTL_DEC_FR]) ?
            state_r.rx_fr : state_r.reg_fr;
        state_nxt.out.odd_field = state_r.rx_odd;
        // axi write path
        if (s_axi_awvalid_in && !state_r.aw_held) begin
            state_nxt.aw_held = 1'b1;
            state_nxt.aw_addr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && !state_r.w_held) begin
            state_nxt.w_held = 1'b1;
            state_nxt.w_data = s_axi_wdata_in;
            state_nxt.w_strb = s_axi_wstrb_in;
        end
        do_write = state_r.aw_held && state_r.w_held && !state_r.bvalid;
        wmerged = 32'h0000_0000;
        if (do_write) begin
            state_nxt.aw_held = 1'b0;
            state_nxt.w_held = 1'b0;
            state_nxt.bvalid = 1'b1;
            state_nxt.bresp = known_ofs(state_r.aw_addr) ? rtscd_pkg::RESP_OKAY :
                                                           rtscd_pkg::RESP_SLVERR;
            case (state_r.aw_addr)
                rtscd_pkg::OFS_CTRL: begin
                    wmerged = merge({25'h0, state_r.ctrl}, state_r.w_data, state_r.w_strb);
                    state_nxt.ctrl = wmerged[6:0];
                end
                rtscd_pkg::OFS_SC_INC: begin
                    wmerged = merge({8'h00, state_r.reg_inc}, state_r.w_data, state_r.w_strb);
                    state_nxt.reg_inc = wmerged[rtscd_pkg::INC_W-1:0];
                end
                rtscd_pkg::OFS_FIELD: begin
                    wmerged = merge({31'h0, state_r.reg_fr}, state_r.w_data, state_r.w_strb);
                    state_nxt.reg_fr = wmerged[rtscd_pkg::FLD_FR_SEL];
                end
                default: wmerged = 32'h0000_0000;
            endcase
        end
        if (state_r.bvalid && s_axi_bready_in) begin
            state_nxt.bvalid = 1'b0;
        end
        // axi read path
        if (s_axi_arvalid_in && !state_r.rvalid) begin
            state_nxt.rvalid = 1'b1;
            state_nxt.rresp = known_ofs(s_axi_araddr_in) ? rtscd_pkg::RESP_OKAY :
                                                          rtscd_pkg::RESP_SLVERR;
            case (s_axi_araddr_in)
                rtscd_pkg::OFS_CTRL: state_nxt.rdata = {25'h0, state_r.ctrl};
                rtscd_pkg::OFS_SC_INC: state_nxt.rdata = {8'h00, state_r.reg_inc};
                rtscd_pkg::OFS_FIELD: state_nxt.rdata = {31'h0, state_r.reg_fr};
                rtscd_pkg::OFS_STATUS: state_nxt.rdata = {state_r.frame_cnt[23:0],
                    state_r.out.field_rate_60hz, state_r.out.use_received_inc,
                    state_r.rx_color, state_r.rx_odd, state_r.rx_fr,
                    state_r.rx_reset, state_r.rx_seq, 1'b0};
                rtscd_pkg::OFS_RX_INC: state_nxt.rdata = {8'h00, state_r.rx_inc};
                default: state_nxt.rdata = 32'h0000_0000;
            endcase
        end else if (state_r.rvalid && s_axi_rready_in) begin
            state_nxt.rvalid = 1'b0;
        end
        if (rst_in) begin
            state_nxt = '0;
            state_nxt.rx = rtscd_pkg::RX_IDLE;
            state_nxt.ctrl = rtscd_pkg::RST_CTRL[6:0];
            state_nxt.reg_inc = rtscd_pkg::RST_SC_INC;
        end
    end

    always_ff @(posedge clock_in) begin
        state_r <= state_nxt;
    end

    // accepting while unheld keeps valid-before-ready legal in either order
    assign s_axi_awready_out = !state_r.aw_held;
    assign s_axi_wready_out = !state_r.w_held;
    assign s_axi_bvalid_out = state_r.bvalid;
    assign s_axi_bresp_out = state_r.bresp;
    assign s_axi_arready_out = !state_r.rvalid;
    assign s_axi_rvalid_out = state_r.rvalid;
    assign s_axi_rdata_out = state_r.rdata;
    assign s_axi_rresp_out = state_r.rresp;
    assign decoded_out = state_r.out;
endmodule : rtscd_decoder

// file: logic/rtscd_pkg.sv
/*
 * Package for the real-time subcarrier control decoder: AXI4-Lite register map,
 * field layout of the serial control frame, and the decoded output structure.
 * Assumes a 32-bit AXI4-Lite bus and one line-locked pixel clock.
 */
package rtscd_pkg;
    localparam int unsigned AXI_AW = 8;
    localparam int unsigned INC_W = 24;
    localparam int unsigned LINE_INC_W = 22;
    // serial frame layout, counted in pixel clocks after the start bit
    localparam int unsigned POS_LINE_INC = 0;
    localparam int unsigned POS_SC_INC = 22;
    localparam int unsigned POS_SEQ = 46;
    localparam int unsigned POS_RESET = 47;
    localparam int unsigned POS_FIELD_RATE = 48;
    localparam int unsigned POS_ODD_EVEN = 49;
    localparam int unsigned POS_COLOR = 50;
    localparam int unsigned FRAME_LEN = 51;
    // register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SC_INC = 8'h04;
    localparam logic [7:0] OFS_FIELD = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_RX_INC = 8'h10;
    // control register bits
    localparam int unsigned CTL_ENABLE = 0;
    localparam int unsigned CTL_DEC_PH = 1;
    localparam int unsigned CTL_PH_SEL = 2;
    localparam int unsigned CTL_DEC_FR = 4;
    localparam int unsigned CTL_DEC_COL = 5;
    localparam int unsigned CTL_PAL = 6;
    localparam int unsigned FLD_FR_SEL = 0;
    localparam logic [31:0] RST_CTRL = 32'h0000_0000;
    localparam logic [INC_W-1:0] RST_SC_INC = 24'h000000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        RX_IDLE,
        RX_SHIFT
    } rtscd_rx_e;

    typedef struct packed {
        logic [INC_W-1:0] sc_increment;
        logic use_received_inc;
        logic phase_reset;
        logic invert_line;
        logic field_rate_60hz;
        logic odd_field;
    } rtscd_out_s;
endpackage : rtscd_pkg

// file: testbench/rtscd_properties.sv
/* Port checker for the real-time control decoder.
   Assumes the bind at the foot onto rtscd_decoder and a single clock. */
`timescale 1ns/1ps
module rtscd_properties (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic rtc_serial_in,
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire rtscd_pkg::rtscd_out_s decoded_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    // cycles since the pin was last high; a whole frame fits in 64
    logic [7:0] quiet_r;
    always_ff @(posedge clock_in) begin
        if (rst_in || rtc_serial_in) quiet_r <= 8'h00;
        else if (quiet_r != 8'hFF) quiet_r <= quiet_r + 8'h01;
    end
    b_holds_a: assert property (s_axi_bvalid_out |=> $past(s_axi_bready_in) ||
        (s_axi_bvalid_out && $stable(s_axi_bresp_out))) else $error("bvalid dropped");
    r_holds_a: assert property (s_axi_rvalid_out |=> $past(s_axi_rready_in) ||
        (s_axi_rvalid_out && $stable(s_axi_rdata_out))) else $error("rvalid dropped");
    read_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("no read answer");
    write_answer_a: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
        && s_axi_wready_out |-> ##[1:3] s_axi_bvalid_out) else $error("no write answer");
    aw_busy_a: assert property (s_axi_awvalid_in && s_axi_awready_out |=> !s_axi_awready_out)
        else $error("second address taken");
    reset_pulse_a: assert property (decoded_out.phase_reset |=> !decoded_out.phase_reset)
        else $error("phase reset too long");
    pulse_at_frame_a: assert property (decoded_out.phase_reset |-> quiet_r < 8'h0C)
        else $error("phase reset off frame");
    parity_at_frame_a: assert property ($changed(decoded_out.odd_field) |-> quiet_r < 8'h40)
        else $error("parity off frame");
endmodule : rtscd_properties

bind rtscd_decoder rtscd_properties i_props (.clock_in, .rst_in, .rtc_serial_in,
    .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out,
    .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arvalid_in,
    .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rvalid_out, .s_axi_rready_in, .decoded_out);

// file: testbench/rtscd_rtc_source.sv
/* Model of the video decoder sending one control frame per line.
   Assumes the caller starts each frame only after the previous one ends. */
`timescale 1ns/1ps
module rtscd_rtc_source (
    input wire logic clock_in,
    output logic serial_out
);
    initial serial_out = 1'b0;
    // idle low so that only the start bit opens a frame
    task automatic send(input logic [rtscd_pkg::FRAME_LEN-1:0] frame, input int gap);
        @(posedge clock_in);
        serial_out <= 1'b1;
        for (int i = 0; i < rtscd_pkg::FRAME_LEN; i++) begin
            @(posedge clock_in);
            serial_out <= frame[i];
        end
        @(posedge clock_in);
        serial_out <= 1'b0;
        repeat (gap) @(posedge clock_in);
    endtask : send
endmodule : rtscd_rtc_source

// file: testbench/tb_realtime_subcarrier_control_decode.sv
/* Self-checking bench: random register settings and frames, corner cases first.
   Assumes the decoder, its checker and the frame source model. */
`timescale 1ns/1ps
module tb_realtime_subcarrier_control_decode;
    localparam logic [31:0] CORNER [4] = '{32'h00, 32'h33, 32'h63, 32'h4F};
    logic clk = 1'b0, rst = 1'b1, ser, awready, wready, bvalid, arready, rvalid;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp;
    rtscd_pkg::rtscd_out_s dec;
    int mismatches = 0, checks_done = 0, pulses = 0;
    rtscd_decoder i_dut (.clock_in(clk), .rst_in(rst), .rtc_serial_in(ser),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .decoded_out(dec));
    rtscd_rtc_source i_src (.clock_in(clk), .serial_out(ser));
    initial forever #20 clk = ~clk;
    always @(posedge clk) if (dec.phase_reset === 1'b1) pulses <= pulses + 1;
    task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_reg
    task automatic chk_dec(input rtscd_pkg::rtscd_out_s exp, input rtscd_pkg::rtscd_out_s got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH decoded expected %h seen %h", exp, got);
        end
    endtask : chk_dec
    // handshakes are judged at the falling edge, acted on at the next rising one
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic pa, pw, pb;
        pa = 1'b1;
        pw = 1'b1;
        pb = 1'b1;
        // a fresh edge keeps the previous call's releases from being overwritten
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (pb) begin
            @(negedge clk);
            pa = pa && !awready;
            pw = pw && !wready;
            r = bresp;
            pb = !bvalid;
            @(posedge clk);
            awvalid <= pa;
            wvalid <= pw;
            bready <= pb;
        end
    endtask : axi_write
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic pa, pr;
        pa = 1'b1;
        pr = 1'b1;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (pr) begin
            @(negedge clk);
            pa = pa && !arready;
            d = rdata;
            r = rresp;
            pr = !rvalid;
            @(posedge clk);
            arvalid <= pa;
            rready <= pr;
        end
    endtask : axi_read
    function automatic rtscd_pkg::rtscd_out_s expect_out(logic [31:0] c, logic [23:0] sc,
        logic f, logic [50:0] fr);
        rtscd_pkg::rtscd_out_s e;
        e.use_received_inc = c[0] && (!c[5] || fr[50]);
        e.sc_increment = e.use_received_inc ? fr[45:22] : sc;
        e.phase_reset = 1'b0;
        e.invert_line = c[0] && c[6] && fr[46];
        e.field_rate_60hz = (c[0] && c[4]) ? fr[48] : f;
        e.odd_field = fr[49];
        return e;
    endfunction : expect_out
    task automatic conclude();
        if (mismatches == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        conclude();
    end
    initial begin
        logic [31:0] d, ctl;
        logic [1:0] r;
        logic [50:0] fr;
        logic [23:0] sc;
        logic fld;
        int base;
        rtscd_pkg::rtscd_out_s eo;
        void'($urandom(32'hEE8E));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        axi_read(rtscd_pkg::OFS_CTRL, d, r);
        chk_reg("ctrl reset", rtscd_pkg::RST_CTRL, d);
        axi_write(8'h20, 32'hFFFFFFFF, r);
        chk_reg("bresp unmapped", {30'h0, rtscd_pkg::RESP_SLVERR}, {30'h0, r});
        axi_read(8'h20, d, r);
        chk_reg("rresp unmapped", {30'h0, rtscd_pkg::RESP_SLVERR}, {30'h0, r});
        for (int k = 0; k < 40; k++) begin
            ctl = (k < 4) ? CORNER[k] : $urandom & 32'h7F;
            sc = 24'($urandom);
            fld = 1'($urandom);
            fr = 51'({$urandom, $urandom});
            if (k < 4) fr[47] = 1'b1;
            axi_write(rtscd_pkg::OFS_CTRL, ctl, r);
            chk_reg("bresp ctrl", {30'h0, rtscd_pkg::RESP_OKAY}, {30'h0, r});
            axi_write(rtscd_pkg::OFS_SC_INC, {8'h00, sc}, r);
            axi_write(rtscd_pkg::OFS_FIELD, {31'h0, fld}, r);
            base = pulses;
            i_src.send(fr, 8 + $urandom % 8);
            @(negedge clk);
            eo = expect_out(ctl, sc, fld, fr);
            chk_dec(eo, dec);
            chk_reg("resets", {31'h0, ctl[0] && ctl[1] && ctl[3:2] == 2'h0 && fr[47]},
                32'(pulses - base));
            @(posedge clk);
            axi_read(rtscd_pkg::OFS_RX_INC, d, r);
            chk_reg("rx increment", {8'h00, fr[45:22]}, d);
            axi_read(rtscd_pkg::OFS_STATUS, d, r);
            chk_reg("status", {24'(k + 1), eo.field_rate_60hz, eo.use_received_inc, fr[50:46],
                1'b0}, d);
        end
        conclude();
    end
endmodule : tb_realtime_subcarrier_control_decode
